// >>> shs_cmd_ctrl.sv
/*
 * Command decoder and shutter controller: takes two-byte special commands
 * from the host link, selects the trigger and sync modes, drives the
 * shutter and sync outputs, and saves or restores the configuration.
 * Assumes host bytes arrive as one-cycle strobes on the system clock, the
 * host waits for the completion byte, and an external non-volatile store
 * holds the saved configuration across power-up and reset.
 */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "shs_defs.svh"

// Summary of operation
// (R1) Prefix FA then A0: trigger input no longer changes shutter state.
// (R2) Prefix FA then A1: high-level mode; low trigger holds shutter closed.
// (R3) High-level mode: shutter open while trigger high, closed when low.
// (R4) Prefix FA then A2: low-level mode; low input opens, high closes.
// (R5) Prefix FA then A3: toggle shutter on each trigger rising edge.
// (R6) Prefix FA then A4: toggle shutter on each trigger falling edge.
// (R7) Prefix FA then B0: sync output disabled.
// (R8) Prefix FA then B1: sync output goes high when shutter opens.
// (R9) Prefix FA then B2: sync output goes low when shutter opens.
// (R10) Prefix FA then C0: working configuration becomes factory default.
// (R11) Prefix FA then C1: working configuration is copied to storage.
// (R12) After reset, the last saved configuration becomes working one.
// (R13) Each decoded two-byte command answers with completion byte 0D.
// (R14) One trigger and one sync mode at a time; new replaces old.
module shs_cmd_ctrl
(
	input  wire logic                  i_clk_sys,  // System clock.
	input  wire logic                  i_rst_b,    // Sync reset, low.
	input  wire logic [7:0]            i_rx_byte,  // Host command byte.
	input  wire logic                  i_rx_valid, // Byte strobe.
	output logic      [7:0]            o_tx_byte,  // Answer byte.
	output logic                       o_tx_valid, // Answer strobe.
	input  wire logic                  i_trig_pin, // Trigger input pin.
	output logic                       o_shutter,  // High: shutter open.
	output logic                       o_sync,     // Sync output.
	input  wire logic [`SHS_NV_CFG_W-1:0] i_nv_cfg,   // Stored config.
	input  wire logic                  i_nv_valid, // Store holds config.
	output logic      [`SHS_NV_CFG_W-1:0] o_nv_cfg,   // Config to store.
	output logic                       o_nv_wr,    // Store write pulse.
	input  wire logic [7:0]            i_addr,     // Register address.
	input  wire logic [31:0]           i_wdata,    // Write data.
	input  wire logic                  i_wr,       // Write strobe.
	input  wire logic                  i_rd,       // Read strobe.
	output logic      [31:0]           o_rdata     // Read data, next cycle.
);

	shs_pkg::shs_dec_e  dec_q;
	shs_pkg::shs_dec_e  dec_d;
	shs_pkg::shs_trig_e trig_q;
	shs_pkg::shs_trig_e trig_d;
	shs_pkg::shs_sync_e sync_mode_q;
	shs_pkg::shs_sync_e sync_mode_d;
	logic                      boot_q;
	logic                      boot_d;
	logic                      ack_q;
	logic                      ack_d;
	logic [7:0]                tx_byte_q;
	logic [7:0]                tx_byte_d;
	logic                      nv_wr_q;
	logic                      nv_wr_d;
	logic [`SHS_NV_CFG_W-1:0]  nv_cfg_q;
	logic [`SHS_NV_CFG_W-1:0]  nv_cfg_d;
	logic                      open_q;
	logic                      open_d;
	logic                      sync_q;
	logic                      sync_d;
	logic [31:0]               rdata_q;
	logic [31:0]               rdata_d;
	logic                      trig_lvl;
	logic                      trig_rise;
	logic                      trig_fall;

	// Packs the working modes into the stored configuration word.
	function automatic logic [`SHS_NV_CFG_W-1:0] pack_cfg
	(
		input shs_pkg::shs_trig_e t,
		input shs_pkg::shs_sync_e s
	);
		pack_cfg = {s, t};
	endfunction

	// Decodes a stored or written trigger field; bad codes fall to off.
	function automatic shs_pkg::shs_trig_e to_trig(input logic [2:0] v);
		case (v)
			3'h1:    to_trig = shs_pkg::SHS_TRIG_HIGH;
			3'h2:    to_trig = shs_pkg::SHS_TRIG_LOW;
			3'h3:    to_trig = shs_pkg::SHS_TRIG_RISE;
			3'h4:    to_trig = shs_pkg::SHS_TRIG_FALL;
			default: to_trig = shs_pkg::SHS_TRIG_OFF;
		endcase
	endfunction

	// Decodes a stored or written sync field; bad codes fall to off.
	function automatic shs_pkg::shs_sync_e to_sync(input logic [1:0] v);
		case (v)
			2'h1:    to_sync = shs_pkg::SHS_SYNC_HIGH;
			2'h2:    to_sync = shs_pkg::SHS_SYNC_LOW;
			default: to_sync = shs_pkg::SHS_SYNC_OFF;
		endcase
	endfunction

	shs_pin_sync u_trig_sync
	(
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_pin     (i_trig_pin),
		.o_level   (trig_lvl),
		.o_rise    (trig_rise),
		.o_fall    (trig_fall)
	);

	// Configuration and command decoding. A host command in the same cycle
	// as a register write to the configuration wins, since the host is
	// waiting on its completion byte and must see its choice take effect.
	always_comb
	begin
		dec_d       = dec_q;
		trig_d      = trig_q;
		sync_mode_d = sync_mode_q;
		boot_d      = 1'b0;
		ack_d       = 1'b0;
		nv_wr_d     = 1'b0;
		nv_cfg_d    = nv_cfg_q;
		if (boot_q && i_nv_valid)
		begin
			trig_d      = to_trig(i_nv_cfg[2:0]); // [R12]
			sync_mode_d = to_sync(i_nv_cfg[4:3]); // [R12]
		end
		if (i_wr && i_addr == `SHS_REG_CFG)
		begin
			trig_d = to_trig(
				i_wdata[`SHS_CFG_TRIG_MSB:`SHS_CFG_TRIG_LSB]); // [R14]
			sync_mode_d = to_sync(
				i_wdata[`SHS_CFG_SYNC_MSB:`SHS_CFG_SYNC_LSB]); // [R14]
		end
		if (i_rx_valid)
		begin
			case (dec_q)
				shs_pkg::SHS_DEC_IDLE:
				begin
					if (i_rx_byte == `SHS_CMD_PREFIX)
					begin
						dec_d = shs_pkg::SHS_DEC_PREFIX;
					end
				end
				shs_pkg::SHS_DEC_PREFIX:
				begin
					dec_d = shs_pkg::SHS_DEC_IDLE;
					ack_d = 1'b1; // [R13]
					case (i_rx_byte)
						`SHS_SEL_TRIG_OFF:
							trig_d = shs_pkg::SHS_TRIG_OFF; // [R1] [R14]
						`SHS_SEL_TRIG_HIGH:
							trig_d = shs_pkg::SHS_TRIG_HIGH; // [R2] [R14]
						`SHS_SEL_TRIG_LOW:
							trig_d = shs_pkg::SHS_TRIG_LOW; // [R4] [R14]
						`SHS_SEL_TRIG_RISE:
							trig_d = shs_pkg::SHS_TRIG_RISE; // [R5] [R14]
						`SHS_SEL_TRIG_FALL:
							trig_d = shs_pkg::SHS_TRIG_FALL; // [R6] [R14]
						`SHS_SEL_SYNC_OFF:
							sync_mode_d = shs_pkg::SHS_SYNC_OFF; // [R7]
						`SHS_SEL_SYNC_HIGH:
							sync_mode_d = shs_pkg::SHS_SYNC_HIGH; // [R8]
						`SHS_SEL_SYNC_LOW:
							sync_mode_d = shs_pkg::SHS_SYNC_LOW; // [R9]
						`SHS_SEL_FACTORY:
						begin
							trig_d      = to_trig(`SHS_FACTORY_TRIG); // [R10]
							sync_mode_d = to_sync(`SHS_FACTORY_SYNC); // [R10]
						end
						`SHS_SEL_SAVE:
						begin
							nv_wr_d  = 1'b1; // [R11]
							nv_cfg_d = pack_cfg(trig_q, sync_mode_q); // [R11]
						end
						default:
							ack_d = 1'b0;
					endcase
				end
				default:
					dec_d = shs_pkg::SHS_DEC_IDLE;
			endcase
		end
		tx_byte_d = ack_d ? `SHS_ACK_BYTE : 8'h00; // [R13]
	end

	// Shutter state. A change to the off or an edge mode keeps the present
	// state, so switching to an edge mode does not itself move the shutter.
	always_comb
	begin
		open_d = open_q;
		case (trig_q)
			shs_pkg::SHS_TRIG_OFF:
			begin
				if (i_wr && i_addr == `SHS_REG_SHUT)
				begin
					open_d = i_wdata[`SHS_SHUT_OPEN]; // [R1]
				end
			end
			shs_pkg::SHS_TRIG_HIGH:
				open_d = trig_lvl; // [R2] [R3]
			shs_pkg::SHS_TRIG_LOW:
				open_d = ~trig_lvl; // [R4]
			shs_pkg::SHS_TRIG_RISE:
			begin
				if (trig_rise)
				begin
					open_d = ~open_q; // [R5]
				end
			end
			shs_pkg::SHS_TRIG_FALL:
			begin
				if (trig_fall)
				begin
					open_d = ~open_q; // [R6]
				end
			end
			default:
				open_d = open_q;
		endcase
		case (sync_mode_q)
			shs_pkg::SHS_SYNC_HIGH:
				sync_d = open_d; // [R8]
			shs_pkg::SHS_SYNC_LOW:
				sync_d = ~open_d; // [R9]
			default:
				sync_d = 1'b0; // [R7]
		endcase
	end

	// Register reads; data stand only in the cycle after the strobe.
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (i_rd)
		begin
			case (i_addr)
				`SHS_REG_CFG:
				begin
					rdata_d[`SHS_CFG_TRIG_MSB:`SHS_CFG_TRIG_LSB] = trig_q;
					rdata_d[`SHS_CFG_SYNC_MSB:`SHS_CFG_SYNC_LSB] =
						sync_mode_q;
				end
				`SHS_REG_STATUS:
				begin
					rdata_d[`SHS_ST_OPEN]     = open_q;
					rdata_d[`SHS_ST_TRIG]     = trig_lvl;
					rdata_d[`SHS_ST_SYNC]     = sync_q;
					rdata_d[`SHS_ST_NV_VALID] = i_nv_valid;
					rdata_d[`SHS_ST_DEC_BUSY] =
						(dec_q == shs_pkg::SHS_DEC_PREFIX);
				end
				`SHS_REG_SHUT:
					rdata_d[`SHS_SHUT_OPEN] = open_q;
				default:
					rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Reset takes factory values; boot_q then lets the saved configuration
	// replace them on the first edge after release.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			dec_q       <= shs_pkg::SHS_DEC_IDLE;
			trig_q      <= shs_pkg::SHS_TRIG_OFF;
			sync_mode_q <= shs_pkg::SHS_SYNC_OFF;
			boot_q      <= 1'b1; // [R12]
			ack_q       <= 1'b0;
			tx_byte_q   <= 8'h00;
			nv_wr_q     <= 1'b0;
			nv_cfg_q    <= 5'h00;
			open_q      <= 1'b0;
			sync_q      <= 1'b0;
			rdata_q     <= 32'h0000_0000;
		end
		else
		begin
			dec_q       <= dec_d;
			trig_q      <= trig_d;
			sync_mode_q <= sync_mode_d;
			boot_q      <= boot_d;
			ack_q       <= ack_d;
			tx_byte_q   <= tx_byte_d;
			nv_wr_q     <= nv_wr_d;
			nv_cfg_q    <= nv_cfg_d;
			open_q      <= open_d;
			sync_q      <= sync_d;
			rdata_q     <= rdata_d;
		end
	end

	assign o_tx_byte  = tx_byte_q;
	assign o_tx_valid = ack_q;
	assign o_shutter  = open_q;
	assign o_sync     = sync_q;
	assign o_nv_cfg   = nv_cfg_q;
	assign o_nv_wr    = nv_wr_q;
	assign o_rdata    = rdata_q;

endmodule // shs_cmd_ctrl

// >>> shs_defs.svh
/*
 * Constants for the shutter trigger and sync command block: command bytes,
 * register offsets, field positions and reset values.
 * Assumes it is included by bare name from files that use these macros.
 */
`ifndef SHS_DEFS_SVH
`define SHS_DEFS_SVH

// Command bytes from the host, and the completion byte sent back.
`define SHS_CMD_PREFIX     8'hfa
`define SHS_SEL_TRIG_OFF   8'ha0
`define SHS_SEL_TRIG_HIGH  8'ha1
`define SHS_SEL_TRIG_LOW   8'ha2
`define SHS_SEL_TRIG_RISE  8'ha3
`define SHS_SEL_TRIG_FALL  8'ha4
`define SHS_SEL_SYNC_OFF   8'hb0
`define SHS_SEL_SYNC_HIGH  8'hb1
`define SHS_SEL_SYNC_LOW   8'hb2
`define SHS_SEL_FACTORY    8'hc0
`define SHS_SEL_SAVE       8'hc1
`define SHS_ACK_BYTE       8'h0d

// Register byte offsets.
`define SHS_REG_CFG        8'h00
`define SHS_REG_STATUS     8'h04
`define SHS_REG_SHUT       8'h08

// Field positions.
`define SHS_CFG_TRIG_LSB   0
`define SHS_CFG_TRIG_MSB   2
`define SHS_CFG_SYNC_LSB   4
`define SHS_CFG_SYNC_MSB   5
`define SHS_ST_OPEN        0
`define SHS_ST_TRIG        1
`define SHS_ST_SYNC        2
`define SHS_ST_NV_VALID    3
`define SHS_ST_DEC_BUSY    4
`define SHS_SHUT_OPEN      0

// Reset and factory values.
`define SHS_FACTORY_TRIG   3'h0
`define SHS_FACTORY_SYNC   2'h0
`define SHS_NV_CFG_W       5

// Edges after reset before the trigger filter may report an edge.
`define SHS_SYNC_FILL      3'h4

`endif

// >>> shs_pkg.sv
/*
 * Types for the shutter trigger and sync command block.
 * Assumes the encodings below match the factory values in shs_defs.svh.
 */
package shs_pkg;

	typedef enum logic [2:0]
	{
		SHS_TRIG_OFF,
		SHS_TRIG_HIGH,
		SHS_TRIG_LOW,
		SHS_TRIG_RISE,
		SHS_TRIG_FALL
	} shs_trig_e;

	typedef enum logic [1:0]
	{
		SHS_SYNC_OFF,
		SHS_SYNC_HIGH,
		SHS_SYNC_LOW
	} shs_sync_e;

	typedef enum logic
	{
		SHS_DEC_IDLE,
		SHS_DEC_PREFIX
	} shs_dec_e;

endpackage

// >>> shs_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter and edge pulses.
 * Assumes i_pin is asynchronous to i_clk_sys.
 */
`timescale 1ns/1ps
`include "shs_defs.svh"
module shs_pin_sync
(
	input  wire logic i_clk_sys, // System clock.
	input  wire logic i_rst_b,   // Synchronous reset, active low.
	input  wire logic i_pin,     // Asynchronous pin.
	output logic      o_level,   // Filtered level.
	output logic      o_rise,    // One-cycle pulse on a rise.
	output logic      o_fall     // One-cycle pulse on a fall.
);

	logic meta_q;
	logic mid_q;
	logic last_q;
	logic level_q;
	logic level_d;
	logic rise_q;
	logic rise_d;
	logic fall_q;
	logic fall_d;
	logic [2:0] fill_q;
	logic [2:0] fill_d;

	// The first stage feeds only the second; the filter looks at 2 and 3.
	always_comb
	begin
		level_d = level_q;
		fill_d  = fill_q;
		if (fill_q != `SHS_SYNC_FILL)
		begin
			fill_d = fill_q + 3'h1;
		end
		if (mid_q == last_q)
		begin
			level_d = last_q;
		end
		// No pulse until the stages hold real pin samples, so a pin that
		// sits high through reset is not taken for a fresh rising edge.
		// A genuine edge in the first few cycles after reset is lost.
		rise_d = level_d & ~level_q & (fill_q == `SHS_SYNC_FILL);
		fall_d = ~level_d & level_q & (fill_q == `SHS_SYNC_FILL);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_b)
		begin
			meta_q  <= 1'b0;
			mid_q   <= 1'b0;
			last_q  <= 1'b0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
			fill_q  <= 3'h0;
		end
		else
		begin
			meta_q  <= i_pin;
			mid_q   <= meta_q;
			last_q  <= mid_q;
			level_q <= level_d;
			rise_q  <= rise_d;
			fall_q  <= fall_d;
			fill_q  <= fill_d;
		end
	end

	assign o_level = level_q;
	assign o_rise  = rise_q;
	assign o_fall  = fall_q;

endmodule // shs_pin_sync

// >>> shs_cmd_checker.sv
/*
 * Port checker for the shutter command block.
 * Assumes it is bound to shs_cmd_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module shs_cmd_checker
(
	input wire logic        i_clk_sys,  // Clock.
	input wire logic        i_rst_b,    // Reset, low.
	input wire logic [7:0]  i_rx_byte,  // Host byte.
	input wire logic        i_rx_valid, // Byte strobe.
	input wire logic [7:0]  o_tx_byte,  // Answer byte.
	input wire logic        o_tx_valid, // Answer strobe.
	input wire logic        i_trig_pin, // Trigger pin.
	input wire logic        o_shutter,  // Shutter open.
	input wire logic        o_sync,     // Sync output.
	input wire logic        o_nv_wr,    // Store write.
	input wire logic        i_wr        // Write strobe.
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_save;
		i_rx_valid && i_rx_byte == 8'hfa ##1
			i_rx_valid && i_rx_byte == 8'hc1;
	endsequence

	property p_ack_byte;
		o_tx_valid |-> o_tx_byte == 8'h0d;
	endproperty
	a_ack_byte: assert property (p_ack_byte)
		else $error("bad ack byte");
	property p_ack_cause;
		o_tx_valid |-> $past(i_rx_valid) && ($past(i_rx_byte) inside
			{[8'ha0:8'ha4], [8'hb0:8'hb2], 8'hc0, 8'hc1});
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("stray ack");
	property p_ack_one;
		o_tx_valid |=> !o_tx_valid;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("double ack");
	property p_save;
		s_save |=> o_nv_wr && o_tx_valid;
	endproperty
	a_save: assert property (p_save)
		else $error("save not written");
	property p_nv_cause;
		o_nv_wr |-> o_tx_valid && $past(i_rx_byte) == 8'hc1;
	endproperty
	a_nv_cause: assert property (p_nv_cause)
		else $error("stray save");
	// A configuration write moves the mode one edge and the sync output
	// the next, so it shows up two samples back.
	property p_sync_cause;
		$changed(o_sync) |-> $changed(o_shutter) || o_tx_valid ||
			$past(o_tx_valid) || $past(i_wr, 2) || !$past(i_rst_b, 2) ||
			!$past(i_rst_b, 3);
	endproperty
	a_sync_cause: assert property (p_sync_cause)
		else $error("sync moved");
	property p_hold;
		($stable(i_trig_pin) && !i_wr && !i_rx_valid) [*8]
			|=> $stable(o_shutter);
	endproperty
	a_hold: assert property (p_hold)
		else $error("shutter moved alone");
	property p_one_change;
		$changed(o_shutter) |=> $stable(o_shutter);
	endproperty
	a_one_change: assert property (p_one_change)
		else $error("double toggle");
endmodule // shs_cmd_checker

bind shs_cmd_ctrl shs_cmd_checker u_chk
(
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_rx_byte(i_rx_byte),
	.i_rx_valid(i_rx_valid), .o_tx_byte(o_tx_byte), .o_tx_valid(o_tx_valid),
	.i_trig_pin(i_trig_pin), .o_shutter(o_shutter), .o_sync(o_sync),
	.o_nv_wr(o_nv_wr), .i_wr(i_wr)
);

// >>> shs_host_model.sv
/*
 * Host model: sends two-byte commands and waits for the completion byte.
 * Assumes the block answers within a few cycles of the selector.
 */
`timescale 1ns/1ps
`include "shs_defs.svh"
module shs_host_model
(
	input  wire logic       i_clk_sys,  // Clock.
	input  wire logic [7:0] i_tx_byte,  // Answer byte.
	input  wire logic       i_tx_valid, // Answer strobe.
	output logic      [7:0] o_rx_byte,  // Command byte.
	output logic            o_rx_valid  // Byte strobe.
);
	initial
	begin
		o_rx_byte = 8'h00;
		o_rx_valid = 1'b0;
	end
	task automatic cmd(input logic [7:0] sel, output logic ok);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_byte <= `SHS_CMD_PREFIX;
		@(posedge i_clk_sys);
		o_rx_byte <= sel;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		// A released byte line must not keep the selector on it.
		o_rx_byte <= ~sel;
		ok = 1'b0;
		repeat (4) @(negedge i_clk_sys)
			if (i_tx_valid === 1'b1 && i_tx_byte === `SHS_ACK_BYTE)
				ok = 1'b1;
	endtask
endmodule // shs_host_model

// >>> testbench.sv
/*
 * Self-checking bench for the shutter command block.
 * Assumes the bound checker and the host model beside it.
 */
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0, rst_b = 1'b0, pin = 1'b0, nv_v = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, tx_valid, rx_valid, shut, sync, nv_wr;
	logic [7:0]  addr = 8'h00, rx_byte, tx_byte;
	logic [4:0]  nv_i = 5'h00, nv_o;
	logic [31:0] wdata = 32'h0, rdata, d;
	int          num_errors = 0, n_checks = 0, cyc = 0;

	shs_cmd_ctrl uut
	(
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_rx_byte(rx_byte),
		.i_rx_valid(rx_valid), .o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
		.i_trig_pin(pin), .o_shutter(shut), .o_sync(sync), .i_nv_cfg(nv_i),
		.i_nv_valid(nv_v), .o_nv_cfg(nv_o), .o_nv_wr(nv_wr), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata)
	);
	shs_host_model host
	(
		.i_clk_sys(clk), .i_tx_byte(tx_byte), .i_tx_valid(tx_valid),
		.o_rx_byte(rx_byte), .o_rx_valid(rx_valid)
	);

	initial
	begin
		forever #4 clk = ~clk;
	end
	// The bench plays the non-volatile store.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (nv_wr === 1'b1)
		begin
			nv_i <= nv_o;
			nv_v <= 1'b1;
		end
		if (cyc == 5000)
		begin
			num_errors = num_errors + 1;
			summarize();
		end
	end

	task automatic summarize();
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
			num_errors = num_errors + 1;
		end
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask
	task automatic rg(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= w;
		rd <= ~w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic pin_to(input logic v);
		@(posedge clk);
		pin <= v;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic go(input logic [7:0] s);
		logic ok;
		host.cmd(s, ok);
		chk(ok, 1);
	endtask

	task automatic t_level();
		logic ok;
		host.cmd(8'h55, ok);
		chk(ok, 0);
		go(8'ha1);
		pin_to(1'b0);
		chk(shut, 0);
		pin_to(1'b1);
		chk(shut, 1);
		go(8'ha2);
		chk(shut, 0);
		pin_to(1'b0);
		chk(shut, 1);
		rg(1'b0, 8'h00, 32'h0);
		chk(d, 32'h2);
		go(8'ha0);
		pin_to(1'b1);
		chk(shut, 1);
		rg(1'b1, 8'h08, 32'h0);
		chk(shut, 0);
		rg(1'b0, 8'h0c, 32'h0);
		chk(d, 32'h0);
		rg(1'b0, 8'h04, 32'h0);
		chk(d, 32'h2);
	endtask
	task automatic t_edge();
		logic s;
		pin_to(1'b0);
		go(8'ha3);
		s = shut;
		pin_to(1'b1);
		chk(shut, !s);
		pin_to(1'b0);
		chk(shut, !s);
		go(8'ha4);
		pin_to(1'b1);
		chk(shut, !s);
		pin_to(1'b0);
		chk(shut, s);
	endtask
	task automatic t_sync();
		logic [7:0] sel [4];
		logic       e [4];
		sel = '{8'hb1, 8'hb2, 8'hb1, 8'hb0};
		e = '{1'b1, 1'b0, 1'b1, 1'b0};
		go(8'ha1);
		pin_to(1'b1);
		for (int i = 0; i < 4; i++)
		begin
			go(sel[i]);
			@(negedge clk);
			chk(sync, e[i]);
		end
		rg(1'b1, 8'h00, 32'h14);
		rg(1'b0, 8'h00, 32'h0);
		chk(d, 32'h14);
		chk(sync, 1);
	endtask
	task automatic t_save();
		go(8'ha3);
		go(8'hb1);
		go(8'hc1);
		chk(nv_i, 5'h0b);
		go(8'hc0);
		rg(1'b0, 8'h00, 32'h0);
		chk(d, 32'h0);
		do_reset();
		rg(1'b0, 8'h00, 32'h0);
		chk(d, 32'h13);
		pin_to(1'b1);
		chk(shut, 0);
		pin_to(1'b0);
		pin_to(1'b1);
		chk(shut, 1);
		chk(sync, 1);
	endtask

	initial
	begin
		do_reset();
		t_level();
		t_edge();
		t_sync();
		t_save();
		summarize();
	end
endmodule // testbench
